// ---- rtl/xrs_strobe_decode.sv ----
// Strobe and decode logic for the RTC strobes, peripheral buffer direction and INIT.
// Assumes ISA commands, decode hits and configuration are synchronous to clk_i.
//
// Summary of operation
// - Keyboard reset request drives processor INIT
// - Port 70h write pulses address latch strobe
// - Strobe rises on IOW fall, two SYSCLKs
// - Strobe low in and after reset
// - Select low during port 71h accesses
// - Strobe and select can become outputs
// - Select and direction high in reset
// - Direction output steers peripheral data buffer
// - Direction low for every I/O read
// - Memory reads only for firmware or APIC
// - PCI reads assert on command fall
// - ISA memory reads need firmware decode only
// - Negate direction on read command rise
// - DMA reads follow acknowledge edges
// - Direction otherwise held high
// - Direction can become general output
module xrs_strobe_decode
  import xrs_pkg::*;
#(
  parameter int SYSCLK_DIV = 12
) (
  input  wire logic         clk_i,
  input  wire logic         sys_rst_i,
  input  wire logic         ce_i,
  input  wire xrs_cmd_t     cmd_i,
  input  wire logic         dma_rd_i,
  input  wire logic         kbc_rst_req_i,
  input  wire xrs_gpo_cfg_t gpo_cfg_i,
  output logic              cpu_init_o,
  output logic              rtc_addr_latch_strobe_o,
  output logic              rtc_select_n_o,
  output logic              periph_buf_dir_n_o
);

  initial begin
    if (SYSCLK_DIV < 1) $error("xrs_strobe_decode: SYSCLK_DIV must be at least 1");
  end

  localparam int CW = $clog2(SYSCLK_DIV * XRS_ALE_SYSCLKS + 1);
  localparam logic [CW-1:0] ALE_CYCLES = CW'(SYSCLK_DIV * XRS_ALE_SYSCLKS);

  // ==========================================================================
  // Command edges
  logic [3:0] fall;
  logic [3:0] rise;

  xrs_edge_det #(
    .W (4)
  ) u_edges (
    .clk_i     (clk_i),
    .sys_rst_i (sys_rst_i),
    .ce_i      (ce_i),
    .sig_i     ({cmd_i.dack_n, cmd_i.memr_n, cmd_i.iow_n, cmd_i.ior_n}),
    .fall_o    (fall),
    .rise_o    (rise)
  );

  logic ior_fall;
  logic iow_fall;
  logic memr_fall;
  logic dack_fall;
  logic ior_rise;
  logic memr_rise;
  logic dack_rise;
  assign ior_fall  = fall[0];
  assign iow_fall  = fall[1];
  assign memr_fall = fall[2];
  assign dack_fall = fall[3];
  assign ior_rise  = rise[0];
  assign memr_rise = rise[2];
  assign dack_rise = rise[3];

  // ==========================================================================
  // INIT request
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      cpu_init_o <= XRS_INIT_RST;
    end else if (ce_i) begin
      cpu_init_o <= kbc_rst_req_i;
    end
  end

  // ==========================================================================
  // Address latch strobe
  logic [CW-1:0] ale_cnt_q;
  logic          ale_hit;
  assign ale_hit = iow_fall && (cmd_i.io_addr == XRS_RTC_ADDR_PORT);

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      ale_cnt_q <= '0;
    end else if (ce_i) begin
      if (ale_hit) begin
        ale_cnt_q <= ALE_CYCLES;
      end else if (ale_cnt_q != '0) begin
        ale_cnt_q <= ale_cnt_q - CW'(1);
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      rtc_addr_latch_strobe_o <= XRS_ALE_RST;
    end else if (ce_i) begin
      if (gpo_cfg_i.ale_gpo_en) begin
        rtc_addr_latch_strobe_o <= gpo_cfg_i.ale_gpo_val;
      end else begin
        rtc_addr_latch_strobe_o <= ale_hit || (ale_cnt_q > CW'(1));
      end
    end
  end

  // ==========================================================================
  // RTC select
  logic sel_hit;
  assign sel_hit = (~cmd_i.ior_n | ~cmd_i.iow_n) && (cmd_i.io_addr == XRS_RTC_DATA_PORT);

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      rtc_select_n_o <= XRS_SEL_N_RST;
    end else if (ce_i) begin
      if (gpo_cfg_i.sel_gpo_en) begin
        rtc_select_n_o <= gpo_cfg_i.sel_gpo_val;
      end else begin
        rtc_select_n_o <= ~sel_hit;
      end
    end
  end

  // ==========================================================================
  // Buffer direction
  logic dir_act_q;
  logic mem_ok;
  assign mem_ok = cmd_i.isa_master ? cmd_i.bios_hit
                                   : (cmd_i.bios_hit | cmd_i.apic_hit);

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      dir_act_q <= 1'b0;
    end else if (ce_i) begin
      if (ior_rise || memr_rise || (dma_rd_i && dack_rise)) begin
        dir_act_q <= 1'b0;
      end else if (ior_fall) begin
        dir_act_q <= 1'b1;
      end else if (memr_fall && mem_ok) begin
        dir_act_q <= 1'b1;
      end else if (dma_rd_i && dack_fall) begin
        dir_act_q <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      periph_buf_dir_n_o <= XRS_DIR_N_RST;
    end else if (ce_i) begin
      if (gpo_cfg_i.dir_gpo_en) begin
        periph_buf_dir_n_o <= gpo_cfg_i.dir_gpo_val;
      end else begin
        periph_buf_dir_n_o <= ~dir_act_q;
      end
    end
  end

endmodule // xrs_strobe_decode

// ---- rtl/xrs_pkg.sv ----
// Package: constants and carrier types for the peripheral-bus strobe decode block.
// Assumes a single 100 MHz clock and ISA commands sampled synchronously.
package xrs_pkg;

  // ==========================================================================
  // Port decode
  localparam logic [15:0] XRS_RTC_ADDR_PORT  = 16'h0070;
  localparam logic [15:0] XRS_RTC_DATA_PORT  = 16'h0071;

  // ==========================================================================
  // Timing
  localparam int          XRS_CLK_PERIOD_NS  = 10;
  localparam int          XRS_ALE_SYSCLKS    = 2;

  // ==========================================================================
  // Reset values
  localparam logic        XRS_ALE_RST        = 1'b0;
  localparam logic        XRS_SEL_N_RST      = 1'b1;
  localparam logic        XRS_DIR_N_RST      = 1'b1;
  localparam logic        XRS_INIT_RST       = 1'b0;

  // ==========================================================================
  // Carriers
  typedef struct packed {
    logic        ior_n;
    logic        iow_n;
    logic        memr_n;
    logic        dack_n;
    logic        isa_master;
    logic        bios_hit;
    logic        apic_hit;
    logic [15:0] io_addr;
  } xrs_cmd_t;

  typedef struct packed {
    logic ale_gpo_en;
    logic ale_gpo_val;
    logic sel_gpo_en;
    logic sel_gpo_val;
    logic dir_gpo_en;
    logic dir_gpo_val;
  } xrs_gpo_cfg_t;

endpackage : xrs_pkg

// ---- rtl/xrs_edge_det.sv ----
// Edge detector: one-cycle pulses on falling and rising edges of a vector.
// Assumes inputs synchronous to clk_i.
module xrs_edge_det
  import xrs_pkg::*;
#(
  parameter int W = 4
) (
  input  wire logic         clk_i,
  input  wire logic         sys_rst_i,
  input  wire logic         ce_i,
  input  wire logic [W-1:0] sig_i,
  output logic      [W-1:0] fall_o,
  output logic      [W-1:0] rise_o
);

  initial begin
    if (W < 1) $error("xrs_edge_det: W must be at least 1");
  end

  logic [W-1:0] prev_q;

  // ==========================================================================
  // History, idles high as the strobes are active low
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      prev_q <= '1;
    end else if (ce_i) begin
      prev_q <= sig_i;
    end
  end

  genvar g;
  generate
    for (g = 0; g < W; g++) begin : g_bit
      assign fall_o[g] = prev_q[g] & ~sig_i[g];
      assign rise_o[g] = ~prev_q[g] & sig_i[g];
    end
  endgenerate

endmodule // xrs_edge_det

// ---- testbench/xrs_strobe_decode_properties.sv ----
// Checker for the ports of the strobe decode block.
// Assumes one clock; paused in reset, with ce_i low or in gpo mode.
module xrs_strobe_decode_properties
  import xrs_pkg::*;
#(parameter int SYSCLK_DIV = 12) (
  input wire logic         clk_i,
  input wire logic         sys_rst_i,
  input wire logic         ce_i,
  input wire xrs_cmd_t     cmd_i,
  input wire logic         dma_rd_i,
  input wire logic         kbc_rst_req_i,
  input wire xrs_gpo_cfg_t gpo_cfg_i,
  input wire logic         cpu_init_o,
  input wire logic         rtc_addr_latch_strobe_o,
  input wire logic         rtc_select_n_o,
  input wire logic         periph_buf_dir_n_o
);
  // ======
  // Checks
  default clocking @(posedge clk_i); endclocking
  default disable iff (sys_rst_i || !ce_i || |gpo_cfg_i);
  int hi_q;
  wire sel71 = !(cmd_i.ior_n && cmd_i.iow_n) && cmd_i.io_addr == XRS_RTC_DATA_PORT;
  always_ff @(posedge clk_i) hi_q <= rtc_addr_latch_strobe_o ? hi_q + 1 : 0;
  sequence wr70; $fell(cmd_i.iow_n) && cmd_i.io_addr == XRS_RTC_ADDR_PORT; endsequence
  sequence dir_on; ##3 !periph_buf_dir_n_o; endsequence
  sequence dir_off; ##3 periph_buf_dir_n_o; endsequence
  ale_start_a: assert property (wr70 |-> ##2 rtc_addr_latch_strobe_o)
    else $error("strobe late");
  ale_len_a: assert property ($fell(rtc_addr_latch_strobe_o) |-> hi_q == 2 * SYSCLK_DIV)
    else $error("strobe length");
  ale_cause_a: assert property ($rose(rtc_addr_latch_strobe_o) |->
    $past(!cmd_i.iow_n && cmd_i.io_addr == XRS_RTC_ADDR_PORT, 1)) else $error("stray strobe");
  sel_cause_a: assert property (!rtc_select_n_o |-> $past(sel71))
    else $error("stray select");
  dir_io_a: assert property ($fell(cmd_i.ior_n) |-> dir_on) else $error("io dir");
  dir_mem_a: assert property ($fell(cmd_i.memr_n) |-> ##3 periph_buf_dir_n_o ==
    !(cmd_i.bios_hit || !cmd_i.isa_master && cmd_i.apic_hit)) else $error("mem dir");
  dir_dma_a: assert property ($fell(cmd_i.dack_n) |-> ##3 periph_buf_dir_n_o == !dma_rd_i)
    else $error("dma dir");
  dir_end_a: assert property ($rose(cmd_i.ior_n) || $rose(cmd_i.memr_n) ||
    $rose(cmd_i.dack_n) |-> dir_off) else $error("dir release");
endmodule // xrs_strobe_decode_properties

bind xrs_strobe_decode xrs_strobe_decode_properties #(.SYSCLK_DIV(SYSCLK_DIV)) u_chk (.clk_i,
  .sys_rst_i, .ce_i, .cmd_i, .dma_rd_i, .kbc_rst_req_i, .gpo_cfg_i, .cpu_init_o,
  .rtc_addr_latch_strobe_o, .rtc_select_n_o, .periph_buf_dir_n_o);

// ---- testbench/xrs_rtc_model.sv ----
// Partner: external clock chip behind the board OR gates.
// Assumes command levels come straight from the bench.
module xrs_rtc_model (
  input  wire logic clk_i,
  input  wire logic sel_n_i,
  input  wire logic rd_n_i,
  input  wire logic wr_n_i,
  output int        rd_cnt_o,
  output int        wr_cnt_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // ======
  // Strobes
  logic rd_q = 1'b1, wr_q = 1'b1;
  wire rd_n = sel_n_i | rd_n_i;
  wire wr_n = sel_n_i | wr_n_i;
  always @(posedge clk_i) begin
    rd_q <= rd_n;
    wr_q <= wr_n;
    if (rd_q && !rd_n) rd_cnt_o <= rd_cnt_o + 1;
    if (wr_q && !wr_n) wr_cnt_o <= wr_cnt_o + 1;
  end
endmodule // xrs_rtc_model

// ---- testbench/xrs_strobe_decode_bench.sv ----
// Bench for the strobe decode block: corner and random command cycles.
// Assumes the bound checker and the clock chip model beside it.
module xrs_strobe_decode_bench;
  timeunit 1ns;
  timeprecision 1ns;
  import xrs_pkg::*;
  // ======
  // Harness
  logic clk_i = 1'b0, sys_rst_i = 1'b1, ce_i = 1'b1, dma_rd_i = 1'b0, kbc_rst_req_i = 1'b0;
  logic cpu_init_o, rtc_addr_latch_strobe_o, rtc_select_n_o, periph_buf_dir_n_o;
  xrs_cmd_t cmd_i = {4'hf, 19'h0};
  xrs_gpo_cfg_t gpo_cfg_i = '0;
  int n_errors = 0, comparisons = 0, k, b, rd_cnt, wr_cnt;
  always #5 clk_i = ~clk_i;
  xrs_strobe_decode #(.SYSCLK_DIV(1)) u_dut (.clk_i, .sys_rst_i, .ce_i, .cmd_i, .dma_rd_i,
    .kbc_rst_req_i, .gpo_cfg_i, .cpu_init_o, .rtc_addr_latch_strobe_o, .rtc_select_n_o,
    .periph_buf_dir_n_o);
  xrs_rtc_model u_rtc (.clk_i, .sel_n_i(rtc_select_n_o), .rd_n_i(cmd_i.ior_n),
    .wr_n_i(cmd_i.iow_n), .rd_cnt_o(rd_cnt), .wr_cnt_o(wr_cnt));
  task chk(input logic g, input logic x);
    comparisons++;
    if (g !== x) begin
      n_errors++;
      $display("[ERR] %0t got %b want %b", $time, g, x);
    end
  endtask
  function logic mem_dir(input logic [2:0] m);
    return !(m[1] || !m[2] && m[0]);
  endfunction
  task cyc(input int c, input logic [15:0] a, input logic d);
    cmd_i.io_addr = a;
    cmd_i[22-c] = 1'b0;
    @(posedge clk_i);
    #1 chk(rtc_addr_latch_strobe_o, c == 1 && a == XRS_RTC_ADDR_PORT);
    repeat (2) @(posedge clk_i);
    #1 chk(periph_buf_dir_n_o, d);
    chk(rtc_select_n_o, !(c < 2 && a == XRS_RTC_DATA_PORT));
    cmd_i[22-c] = 1'b1;
    repeat (3) @(posedge clk_i);
    #1 chk(periph_buf_dir_n_o & rtc_select_n_o & !rtc_addr_latch_strobe_o, 1'b1);
  endtask
  task conclude;
    $display("comparisons %0d errors %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    void'($urandom(32'ha2f8));
    repeat (3) @(posedge clk_i);
    #1 chk(cpu_init_o | rtc_addr_latch_strobe_o, 1'b0);
    chk(!rtc_select_n_o | !periph_buf_dir_n_o, 1'b0);
    @(posedge clk_i);
    #1 sys_rst_i = 1'b0;
    cyc(1, XRS_RTC_ADDR_PORT, 1'b1);
    cyc(0, XRS_RTC_ADDR_PORT, 1'b0);
    cyc(0, XRS_RTC_DATA_PORT, 1'b0);
    cyc(1, XRS_RTC_DATA_PORT, 1'b1);
    chk(rd_cnt == 1 && wr_cnt == 1, 1'b1);
    $display("port test done");
    for (k = 0; k < 8; k++) begin
      cmd_i[18:16] = k[2:0];
      cyc(2, 16'($urandom), mem_dir(k[2:0]));
      dma_rd_i = k[0];
      cyc(3, 16'h0000, !k[0]);
    end
    $display("memory and dma test done");
    for (k = 0; k < 12; k++) begin
      b = $urandom % 2;
      cmd_i[18] = 1'($urandom);
      cyc(b, 16'h0070 + 16'($urandom % 4), b[0]);
    end
    $display("random test done");
    for (k = 0; k < 16; k++) begin
      kbc_rst_req_i = 1'($urandom);
      @(posedge clk_i);
      #1 chk(cpu_init_o, kbc_rst_req_i);
    end
    ce_i = 1'b0;
    kbc_rst_req_i = !cpu_init_o;
    @(posedge clk_i);
    #1 chk(cpu_init_o, !kbc_rst_req_i);
    ce_i = 1'b1;
    gpo_cfg_i = 6'h3a;
    repeat (2) @(posedge clk_i);
    #1 chk(rtc_addr_latch_strobe_o & !rtc_select_n_o & !periph_buf_dir_n_o, 1'b1);
    $display("init and gpo test done");
    conclude;
  end
endmodule // xrs_strobe_decode_bench
